// *** rtwo_pkg.sv ***
package rtwo_pkg;
    localparam logic [9:0] IDX_CTL = 10'h108;
    localparam logic [9:0] IDX_OSC = 10'h109;
    localparam logic [9:0] IDX_IOC = 10'h10a;
    localparam logic [9:0] IDX_MODE = 10'h10b;
    localparam logic [9:0] IDX_PRE = 10'h10c;
    localparam logic [9:0] IDX_SEC = 10'h10d;
    localparam logic [9:0] IDX_PRI = 10'h10e;
    localparam logic [1:0] OP_TIMER = 2'h0;
    localparam logic [1:0] OP_WAVE = 2'h1;
    localparam logic [1:0] OP_ONESHOT = 2'h2;
    localparam logic [1:0] OP_WAITOS = 2'h3;
    localparam logic [1:0] CKS_F1 = 2'h0;
    localparam logic [1:0] CKS_F8 = 2'h1;
    localparam logic [1:0] CKS_COMP = 2'h2;
    localparam logic [1:0] CKS_F2 = 2'h3;
    localparam logic [7:0] CNT_RST = 8'hff;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam int BIT_RUN = 0;
    localparam int BIT_STATUS = 1;
    localparam int BIT_FSTOP = 2;
    localparam int BIT_OS_START = 0;
    localparam int BIT_OS_STOP = 1;
    localparam int BIT_OS_ACTIVE = 2;
    localparam int ANSWER_CYCLES = 2;

    typedef struct packed {
        logic pin_trigger_polarity;
        logic pin_trigger_enable;
        logic output_source_switch;
        logic output_level_select;
    } rtwo_ioc_type;

    typedef struct packed {
        logic cutoff;
        logic [1:0] clk_sel;
        logic write_target_select;
        logic [1:0] op_mode_select;
    } rtwo_mode_type;
endpackage

// *** rtwo_timer.sv ***
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/10ps
module rtwo_timer (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [11:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_companion_uf,
    input wire logic i_ext_trigger_pin,
    input wire logic i_port_latch_bit,
    output logic o_wave_out_pin,
    output logic o_irq
);
    typedef enum logic {PH_PRIMARY, PH_SECONDARY} rtwo_phase_type;

    logic wait_q;
    logic [31:0] rdata_q;
    logic run_q;
    logic active_q;
    rtwo_pkg::rtwo_ioc_type ioc_q;
    rtwo_pkg::rtwo_mode_type mode_q;
    logic [7:0] pre_rld_q;
    logic [7:0] pre_cnt_q;
    logic [7:0] pri_rld_q;
    logic [7:0] sec_rld_q;
    logic [7:0] sec_buf_q;
    logic [7:0] tmr_cnt_q;
    logic pre_pend_q;
    logic tmr_pend_q;
    rtwo_phase_type phase_q;
    logic [2:0] div_q;
    logic sync1_q;
    logic sync2_q;
    logic sync3_q;
    logic ev_q;
    logic src_sw_eff_q;
    logic wave_q;
    logic irq_q;

    // bus decode: request taken at first edge, committed when wait is low
    logic req;
    logic commit;
    logic [9:0] idx;
    logic [7:0] wd;
    logic wr_ctl;
    logic wr_osc;
    logic wr_pre;
    logic wr_pri;
    logic wr_sec;
    assign req = i_avs_read | i_avs_write;
    assign commit = i_avs_write & ~wait_q & i_avs_byteenable[0];
    assign idx = i_avs_address[11:2];
    assign wd = i_avs_writedata[7:0];
    assign wr_ctl = commit && idx == rtwo_pkg::IDX_CTL;
    assign wr_osc = commit && idx == rtwo_pkg::IDX_OSC;
    assign wr_pre = commit && idx == rtwo_pkg::IDX_PRE;
    assign wr_pri = commit && idx == rtwo_pkg::IDX_PRI;
    assign wr_sec = commit && idx == rtwo_pkg::IDX_SEC;

    logic is_timer;
    logic is_wave;
    logic is_os;
    assign is_timer = mode_q.op_mode_select == rtwo_pkg::OP_TIMER;
    assign is_wave = mode_q.op_mode_select == rtwo_pkg::OP_WAVE;
    // the wait variant is not built; it behaves as plain one-shot
    assign is_os = mode_q.op_mode_select[1];

    logic fstop;
    logic run_off;
    logic start_evt;
    assign fstop = wr_ctl && wd[rtwo_pkg::BIT_FSTOP];
    assign run_off = wr_ctl && !wd[rtwo_pkg::BIT_RUN];
    assign start_evt = wr_ctl && wd[rtwo_pkg::BIT_RUN] && !fstop && !run_q;

    // count source selection and ticks
    logic ct_en;
    logic sel_tick;
    logic src_tick;
    logic pre_uf;
    logic tmr_uf;
    assign ct_en = is_os ? active_q : run_q;
    always_comb
    begin
        case (mode_q.clk_sel)
            rtwo_pkg::CKS_F1: sel_tick = 1'b1;
            rtwo_pkg::CKS_F8: sel_tick = div_q == 3'h7;
            rtwo_pkg::CKS_F2: sel_tick = div_q[0];
            rtwo_pkg::CKS_COMP: sel_tick = i_companion_uf;
            default: sel_tick = 1'b0;
        endcase
    end
    assign src_tick = sel_tick & ~mode_q.cutoff & ct_en;
    assign pre_uf = src_tick && pre_cnt_q == 8'h00 && !pre_pend_q;
    assign tmr_uf = pre_uf && tmr_cnt_q == 8'h00 && !tmr_pend_q;

    // pin trigger, synchronised; the edge is taken from the second and third stages
    logic pin_edge;
    logic os_trig;
    logic os_end;
    assign pin_edge = ioc_q.pin_trigger_polarity ? (sync2_q & ~sync3_q)
                                                 : (~sync2_q & sync3_q);
    assign os_trig = is_os && run_q && !active_q &&
        ((wr_osc && wd[rtwo_pkg::BIT_OS_START]) ||
         (ioc_q.pin_trigger_enable && pin_edge));
    assign os_end = is_os && (tmr_uf || run_off || fstop ||
        (wr_osc && wd[rtwo_pkg::BIT_OS_STOP]));

    logic wr_both;
    assign wr_both = is_timer && !mode_q.write_target_select;

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
            div_q <= 3'h0;
        end
        else
        begin
            sync1_q <= i_ext_trigger_pin;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            div_q <= div_q + 3'h1;
        end
    end

    // avalon slave, fixed answer one cycle after the request is seen
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            wait_q <= 1'b1;
            rdata_q <= 32'h0;
        end
        else
        begin
            wait_q <= ~(req & wait_q);
            if (req && wait_q)
            begin
                rdata_q <= 32'h0;
                case (idx)
                    rtwo_pkg::IDX_CTL: rdata_q[2:0] <= {1'b0,
                        (is_os ? active_q : run_q), run_q};
                    rtwo_pkg::IDX_OSC:
                        rdata_q[rtwo_pkg::BIT_OS_ACTIVE] <= active_q;
                    rtwo_pkg::IDX_IOC: rdata_q[3:0] <= ioc_q;
                    rtwo_pkg::IDX_MODE: rdata_q[7:0] <= {mode_q.cutoff,
                        1'b0, mode_q.clk_sel, mode_q.write_target_select,
                        1'b0, mode_q.op_mode_select};
                    rtwo_pkg::IDX_PRE: rdata_q[7:0] <= pre_cnt_q;
                    rtwo_pkg::IDX_PRI: rdata_q[7:0] <= tmr_cnt_q;
                    default: rdata_q <= 32'h0;
                endcase
            end
        end
    end

    // configuration registers
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ioc_q <= '0;
            mode_q <= '0;
        end
        else
        begin
            if (commit && idx == rtwo_pkg::IDX_IOC)
                ioc_q <= wd[3:0];
            if (commit && idx == rtwo_pkg::IDX_MODE)
            begin
                mode_q.cutoff <= wd[7];
                mode_q.clk_sel <= wd[5:4];
                mode_q.write_target_select <= wd[3];
                mode_q.op_mode_select <= wd[1:0];
            end
        end
    end

    // run and one-shot flags
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            run_q <= 1'b0;
            active_q <= 1'b0;
        end
        else
        begin
            if (fstop)
                run_q <= 1'b0;
            else if (wr_ctl)
                run_q <= wd[rtwo_pkg::BIT_RUN];
            // a trigger while active is not a retrigger, so end wins here
            if (os_end || !is_os)
                active_q <= 1'b0;
            else if (os_trig)
                active_q <= 1'b1;
        end
    end

    // prescaler stage
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            pre_rld_q <= rtwo_pkg::CNT_RST;
            pre_cnt_q <= rtwo_pkg::CNT_RST;
            pre_pend_q <= 1'b0;
        end
        else if (fstop)
        begin
            pre_rld_q <= rtwo_pkg::CNT_RST;
            pre_cnt_q <= rtwo_pkg::CNT_RST;
            pre_pend_q <= 1'b0;
        end
        else
        begin
            if (wr_pre)
                pre_rld_q <= wd;
            if (wr_pre && !run_q)
                pre_cnt_q <= wd;
            else if (os_end)
                pre_cnt_q <= pre_rld_q;
            else if (src_tick)
                pre_cnt_q <= (pre_pend_q || pre_cnt_q == 8'h00) ?
                             pre_rld_q : pre_cnt_q - 8'h01;
            // a write landing on the tick stays pending for the next one
            if (wr_pre && run_q && wr_both)
                pre_pend_q <= 1'b1;
            else if (src_tick || !run_q)
                pre_pend_q <= 1'b0;
        end
    end

    // timer stage with primary and secondary reload
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            pri_rld_q <= rtwo_pkg::CNT_RST;
            sec_rld_q <= rtwo_pkg::CNT_RST;
            sec_buf_q <= rtwo_pkg::CNT_RST;
            tmr_cnt_q <= rtwo_pkg::CNT_RST;
            tmr_pend_q <= 1'b0;
            phase_q <= PH_PRIMARY;
        end
        else if (fstop)
        begin
            pri_rld_q <= rtwo_pkg::CNT_RST;
            sec_rld_q <= rtwo_pkg::CNT_RST;
            sec_buf_q <= rtwo_pkg::CNT_RST;
            tmr_cnt_q <= rtwo_pkg::CNT_RST;
            tmr_pend_q <= 1'b0;
            phase_q <= PH_PRIMARY;
        end
        else
        begin
            if (wr_sec)
                sec_buf_q <= wd;
            if (wr_sec && !run_q)
                sec_rld_q <= wd;
            else if (wr_pri && run_q)
                sec_rld_q <= sec_buf_q;
            if (wr_pri)
                pri_rld_q <= wd;
            if (wr_pri && !run_q)
                tmr_cnt_q <= wd;
            else if (os_end)
                tmr_cnt_q <= pri_rld_q;
            else if (pre_uf)
            begin
                if (tmr_pend_q)
                    tmr_cnt_q <= pri_rld_q;
                else if (tmr_cnt_q != 8'h00)
                    tmr_cnt_q <= tmr_cnt_q - 8'h01;
                else if (is_wave && phase_q == PH_PRIMARY)
                    tmr_cnt_q <= sec_rld_q;
                else
                    tmr_cnt_q <= pri_rld_q;
            end
            if (wr_pri && run_q && wr_both)
                tmr_pend_q <= 1'b1;
            else if (pre_uf || !run_q)
                tmr_pend_q <= 1'b0;
            if (start_evt || !is_wave)
                phase_q <= PH_PRIMARY;
            else if (tmr_uf)
                phase_q <= (phase_q == PH_PRIMARY) ? PH_SECONDARY
                                                   : PH_PRIMARY;
        end
    end

    // output pin and request; both move one clock after the underflow
    // edge; a fixed clock stands in for half a source cycle, exact only
    // at the f2 source, whose cycle is two clocks
    logic wave_d;
    always_comb
    begin
        case (mode_q.op_mode_select)
            rtwo_pkg::OP_WAVE:
                if (src_sw_eff_q)
                    wave_d = i_port_latch_bit;
                else if (run_q && phase_q == PH_PRIMARY)
                    wave_d = ~ioc_q.output_level_select;
                else
                    wave_d = ioc_q.output_level_select;
            rtwo_pkg::OP_ONESHOT,
            rtwo_pkg::OP_WAITOS:
                wave_d = active_q ^ ioc_q.output_level_select;
            default:
                wave_d = i_port_latch_bit;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ev_q <= 1'b0;
            irq_q <= 1'b0;
            wave_q <= 1'b0;
            src_sw_eff_q <= 1'b0;
        end
        else
        begin
            ev_q <= tmr_uf && (is_timer || (is_os && active_q) ||
                    (is_wave && phase_q == PH_SECONDARY));
            irq_q <= ev_q;
            wave_q <= wave_d;
            if (start_evt || ev_q)
                src_sw_eff_q <= ioc_q.output_source_switch;
        end
    end

    assign o_avs_readdata = rdata_q;
    assign o_avs_waitrequest = wait_q;
    assign o_wave_out_pin = wave_q;
    assign o_irq = irq_q;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    AST_FSTOP_ONES: assert property (fstop |=>
        pre_rld_q == 8'hff && pri_rld_q == 8'hff && sec_rld_q == 8'hff)
        else $error("forced stop did not set registers to all ones");
    AST_FSTOP_HALTS: assert property (fstop |=> !run_q && !active_q)
        else $error("forced stop did not halt counting");
    AST_IRQ_PULSE: assert property (o_irq |=> !o_irq)
        else $error("interrupt request longer than one clock");
    AST_WAVE_IRQ: assert property (
        tmr_uf && is_wave && phase_q == PH_SECONDARY |-> ##2 o_irq)
        else $error("no request after secondary underflow");
    AST_WAVE_TOGGLE: assert property (
        tmr_uf && is_wave && !fstop && !start_evt
        |=> phase_q != $past(phase_q))
        else $error("phase did not alternate at underflow");
    AST_OS_END: assert property (
        is_os && active_q && tmr_uf && !fstop && !commit
        |=> !active_q && tmr_cnt_q == pri_rld_q ##1 o_irq)
        else $error("one-shot end did not reload and clear");
    AST_PRE_SYNC: assert property (
        !src_tick && !wr_pre && !fstop && !os_end |=> $stable(pre_cnt_q))
        else $error("prescaler counter moved without a tick");
    AST_STOPPED_WR: assert property (
        wr_pri && !run_q |=> tmr_cnt_q == $past(wd))
        else $error("stopped write missed the counter");
    AST_RUN_WR_RELOAD: assert property (
        wr_pri && run_q && !wr_both && !pre_uf && !os_end && !fstop
        |=> $stable(tmr_cnt_q))
        else $error("counting write reached the counter");
    AST_BUS_ANSWER: assert property (
        req && wait_q |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
        else $error("bus answer not one cycle wide");

    COV_WAVE_IRQ: cover property (is_wave && o_irq);
    COV_OS_PULSE: cover property (is_os && os_trig ##[1:600] o_irq);
    COV_PIN_TRIG: cover property (pin_edge && os_trig);
    COV_FSTOP_RUN: cover property (run_q && fstop);
endmodule

// *** rtwo_far_model.sv ***
`timescale 1ns/10ps
module rtwo_far_model #(
    parameter int COMP_DIV = 5
)(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_trig_level,
    output logic o_companion_uf,
    output logic o_ext_trigger_pin
);
    int cnt_q;
    // companion stage underflows at a steady rate, one clock wide
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            cnt_q <= 0;
            o_companion_uf <= 1'b0;
        end
        else
        begin
            cnt_q <= (cnt_q == COMP_DIV - 1) ? 0 : cnt_q + 1;
            o_companion_uf <= (cnt_q == COMP_DIV - 1);
        end
    end
    // pin is a plain level; the device does its own sync and edge pick
    assign o_ext_trigger_pin = i_trig_level;
endmodule

// *** reload_timer_waveform_oneshot_tb.sv ***
`timescale 1ns/10ps
`define CHK(a, b) \
begin \
    cmp_count++; \
    if ((a) !== (b)) \
    begin \
        err_total++; \
        $display("unexpected at %0t: got %h exp %h", $time, (a), (b)); \
    end \
end
module reload_timer_waveform_oneshot_tb;
    logic clk, rst, rd, wr, comp_uf, trig_pin, trig_lvl, latch, pin, irq;
    logic wreq, last_pin, irq_rise, irq_fall;
    logic [11:0] address;
    logic [31:0] wdata, rdata;
    logic [7:0] v, w;
    int err_total, cmp_count, run_len, hi_len, lo_len, since, irq_gap;
    logic [1:0] cks_t [4] = '{rtwo_pkg::CKS_F1, rtwo_pkg::CKS_F8,
        rtwo_pkg::CKS_COMP, rtwo_pkg::CKS_F2};
    int gap_t [4] = '{4, 32, 20, 8};
    logic [9:0] idx_t [8] = '{rtwo_pkg::IDX_CTL, rtwo_pkg::IDX_OSC,
        rtwo_pkg::IDX_IOC, rtwo_pkg::IDX_MODE, rtwo_pkg::IDX_PRE,
        rtwo_pkg::IDX_SEC, rtwo_pkg::IDX_PRI, 10'h0ff};
    logic [7:0] exp_t [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00,
        8'hff, 8'h00};

    rtwo_timer dut (
        .i_clk(clk), .i_rst(rst), .i_avs_address(address),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
        .i_avs_byteenable(4'h1), .o_avs_readdata(rdata),
        .o_avs_waitrequest(wreq), .i_companion_uf(comp_uf),
        .i_ext_trigger_pin(trig_pin), .i_port_latch_bit(latch),
        .o_wave_out_pin(pin), .o_irq(irq)
    );
    rtwo_far_model far (
        .i_clk(clk), .i_rst(rst), .i_trig_level(trig_lvl),
        .o_companion_uf(comp_uf), .o_ext_trigger_pin(trig_pin)
    );

    always #5 clk = ~clk;

    // run lengths of the pin and spacing of requests, sampled mid-cycle
    always @(negedge clk)
    begin
        if (pin !== last_pin)
        begin
            if (last_pin === 1'b1)
                hi_len = run_len;
            else
                lo_len = run_len;
            if (pin === 1'b1)
                irq_rise = irq;
            else
                irq_fall = irq;
            run_len = 1;
        end
        else
            run_len++;
        last_pin = pin;
        since++;
        if (irq === 1'b1)
        begin
            irq_gap = since;
            since = 0;
        end
    end

    task automatic acc(input logic is_wr, input logic [9:0] idx,
        input logic [7:0] d);
        @(posedge clk);
        address <= {idx, 2'b00};
        wdata <= {24'h000000, d};
        wr <= is_wr;
        rd <= !is_wr;
        // hold until the edge that sees wait low; the watchdog ends a hang
        do
            @(posedge clk);
        while (wreq !== 1'b0);
        v = rdata[7:0];
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    task automatic wrr(input logic [9:0] idx, input logic [7:0] d);
        acc(1'b1, idx, d);
    endtask

    task automatic rc(input logic [9:0] idx, input logic [7:0] e);
        acc(1'b0, idx, 8'h00);
        `CHK(v, e)
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        err_total++;
        end_of_test;
    end

    initial
    begin
        clk = 0;
        rst = 1;
        rd = 0;
        wr = 0;
        address = 0;
        wdata = 0;
        trig_lvl = 0;
        latch = 0;
        last_pin = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++)
            rc(idx_t[i], exp_t[i]);
        `CHK(pin, 1'b0)
        wrr(rtwo_pkg::IDX_IOC, 8'h00);
        wrr(rtwo_pkg::IDX_PRE, 8'h00);
        wrr(rtwo_pkg::IDX_PRI, 8'h03);
        rc(rtwo_pkg::IDX_PRI, 8'h03);
        for (int i = 0; i < 4; i++)
        begin
            wrr(rtwo_pkg::IDX_MODE, {2'b00, cks_t[i], 4'h0});
            wrr(rtwo_pkg::IDX_CTL, 8'h01);
            wt(120);
            `CHK(irq_gap, gap_t[i])
            wrr(rtwo_pkg::IDX_CTL, 8'h00);
        end
        wt(40);
        `CHK(since > 30, 1'b1)
        // cut-off source: running but no tick, so no request may come
        wrr(rtwo_pkg::IDX_MODE, 8'h80);
        wrr(rtwo_pkg::IDX_CTL, 8'h01);
        wt(40);
        `CHK(since > 60, 1'b1)
        wrr(rtwo_pkg::IDX_CTL, 8'h00);
        // slow source so a counter copy is seen apart from a reload copy
        wrr(rtwo_pkg::IDX_MODE, 8'h18);
        wrr(rtwo_pkg::IDX_PRI, 8'hff);
        wrr(rtwo_pkg::IDX_CTL, 8'h01);
        wrr(rtwo_pkg::IDX_PRI, 8'h03);
        wt(20);
        acc(1'b0, rtwo_pkg::IDX_PRI, 8'h00);
        `CHK(v > 8'h03, 1'b1)
        w = v;
        // f8 ticks only every eighth clock; let one pass between reads
        wt(10);
        acc(1'b0, rtwo_pkg::IDX_PRI, 8'h00);
        `CHK(v < w, 1'b1)
        wrr(rtwo_pkg::IDX_CTL, 8'h00);
        wrr(rtwo_pkg::IDX_MODE, 8'h10);
        wrr(rtwo_pkg::IDX_PRI, 8'hff);
        wrr(rtwo_pkg::IDX_CTL, 8'h01);
        wrr(rtwo_pkg::IDX_PRI, 8'h03);
        wt(20);
        acc(1'b0, rtwo_pkg::IDX_PRI, 8'h00);
        `CHK(v <= 8'h03, 1'b1)
        wrr(rtwo_pkg::IDX_CTL, 8'h04);
        rc(rtwo_pkg::IDX_PRE, 8'hff);
        rc(rtwo_pkg::IDX_PRI, 8'hff);
        rc(rtwo_pkg::IDX_CTL, 8'h00);
        wrr(rtwo_pkg::IDX_MODE, 8'h09);
        wrr(rtwo_pkg::IDX_IOC, 8'h00);
        wrr(rtwo_pkg::IDX_PRE, 8'h00);
        wrr(rtwo_pkg::IDX_SEC, 8'h04);
        wrr(rtwo_pkg::IDX_PRI, 8'h02);
        wrr(rtwo_pkg::IDX_CTL, 8'h01);
        wt(60);
        `CHK(hi_len, 3)
        `CHK(lo_len, 5)
        `CHK(irq_rise, 1'b1)
        `CHK(irq_fall, 1'b0)
        `CHK(irq_gap, 8)
        wrr(rtwo_pkg::IDX_SEC, 8'h01);
        wt(60);
        `CHK(lo_len, 5)
        wrr(rtwo_pkg::IDX_PRI, 8'h02);
        wt(60);
        `CHK(lo_len, 2)
        wrr(rtwo_pkg::IDX_CTL, 8'h00);
        wt(4);
        `CHK(pin, 1'b0)
        wrr(rtwo_pkg::IDX_IOC, 8'h01);
        wt(4);
        `CHK(pin, 1'b1)
        wrr(rtwo_pkg::IDX_CTL, 8'h01);
        wt(60);
        `CHK(lo_len, 3)
        `CHK(hi_len, 2)
        latch <= 1'b1;
        wrr(rtwo_pkg::IDX_IOC, 8'h03);
        wt(60);
        `CHK(run_len > 20, 1'b1)
        latch <= 1'b0;
        wt(4);
        `CHK(pin, 1'b0)
        wrr(rtwo_pkg::IDX_CTL, 8'h04);
        wrr(rtwo_pkg::IDX_IOC, 8'h00);
        wrr(rtwo_pkg::IDX_MODE, 8'h0a);
        wrr(rtwo_pkg::IDX_PRE, 8'h01);
        wrr(rtwo_pkg::IDX_PRI, 8'h09);
        wrr(rtwo_pkg::IDX_CTL, 8'h01);
        irq_fall = 0;
        wrr(rtwo_pkg::IDX_OSC, 8'h01);
        rc(rtwo_pkg::IDX_OSC, 8'h04);
        wt(40);
        `CHK(hi_len, 20)
        `CHK(irq_fall, 1'b1)
        rc(rtwo_pkg::IDX_OSC, 8'h00);
        wrr(rtwo_pkg::IDX_OSC, 8'h01);
        wrr(rtwo_pkg::IDX_OSC, 8'h02);
        wt(3);
        `CHK(pin, 1'b0)
        rc(rtwo_pkg::IDX_PRI, 8'h09);
        hi_len = 0;
        wrr(rtwo_pkg::IDX_IOC, 8'h0c);
        trig_lvl <= 1'b1;
        wt(40);
        `CHK(hi_len, 20)
        hi_len = 0;
        wrr(rtwo_pkg::IDX_IOC, 8'h08);
        trig_lvl <= 1'b0;
        wt(5);
        trig_lvl <= 1'b1;
        wt(40);
        `CHK(hi_len, 0)
        wrr(rtwo_pkg::IDX_IOC, 8'h04);
        trig_lvl <= 1'b0;
        wt(40);
        `CHK(hi_len, 20)
        hi_len = 0;
        wrr(rtwo_pkg::IDX_IOC, 8'h00);
        wrr(rtwo_pkg::IDX_OSC, 8'h01);
        wrr(rtwo_pkg::IDX_PRI, 8'h04);
        wt(40);
        `CHK(hi_len, 20)
        wrr(rtwo_pkg::IDX_OSC, 8'h01);
        wt(30);
        `CHK(hi_len, 10)
        hi_len = 0;
        wrr(rtwo_pkg::IDX_OSC, 8'h01);
        wrr(rtwo_pkg::IDX_CTL, 8'h00);
        wt(3);
        `CHK(pin, 1'b0)
        wt(20);
        `CHK(hi_len < 10, 1'b1)
        end_of_test;
    end
endmodule
